// >>> psw_pkg.sv
// Purpose: Constants and carrier types for the processor status word bank
// Assumes: 32-bit status word, single-cycle register port
// Notes:   Field positions follow the classic status word layout
package psw_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_STATUS   = 4'h0;
    localparam logic [3:0]  ADDR_PENDING  = 4'h1;
    localparam logic [3:0]  ADDR_EVENT    = 4'h2;
    localparam logic [31:0] STATUS_RESET  = 32'h0040_0004;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int COP_USABLE_LSB = 28;
    localparam int LOW_POWER_BIT  = 27;
    localparam int FPU_REGS_BIT   = 26;
    localparam int BYTE_SWAP_BIT  = 25;
    localparam int DIAG_LSB       = 16;
    localparam int BOOT_VEC_BIT   = 22;
    localparam int SHUTDOWN_BIT   = 21;
    localparam int SOFT_RST_BIT   = 20;
    localparam int L2_HIT_BIT     = 18;
    localparam int CHECK_OVR_BIT  = 17;
    localparam int PARITY_DIS_BIT = 16;
    localparam int INT_MASK_LSB   = 8;
    localparam int KERN_WIDE_BIT  = 7;
    localparam int SUP_WIDE_BIT   = 6;
    localparam int USER_WIDE_BIT  = 5;
    localparam int PRIV_MODE_LSB  = 3;
    localparam int ERR_LEVEL_BIT  = 2;
    localparam int EXC_LEVEL_BIT  = 1;
    localparam int INT_ENABLE_BIT = 0;

    // Writable bits: all but shutdown, lookup hit and reserved bits
    localparam logic [31:0] WRITE_MASK = 32'hFE57_FFFF;
    localparam logic [31:0] READ_MASK  = 32'hFE77_FFFF;

    // Low power divider: one enable pulse every CLK_DIV_LAST + 1 (four) cycles
    localparam logic [1:0] CLK_DIV_LAST = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MODE_KERNEL = 3'b001,
        MODE_SUPER  = 3'b010,
        MODE_USER   = 3'b100
    } psw_mode_e;

    typedef struct packed
    {
        logic [3:0] cop_usable;
        logic       fpr32;
        logic       byte_swap;
        logic       wide_addr;
        logic       wide_ops;
        logic       boot_vectors;
        logic       check_override;
        logic       parity_trap_disable;
        logic       int_request;
    } psw_ctrl_s;

endpackage

// >>> psw_status_reg.sv
// Purpose: Processor status word register with decoded control outputs
// Assumes: Privileged move logic raises the strobes; same clock as core
// Notes:   Read data valid the cycle after the read strobe only
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - Four coprocessor usable bits, one each
// - Coprocessor zero always usable in kernel
// - Low power bit slows internal clock enable
// - Register count bit: 16 or 32
// - Byte swap applies in user mode only
// - Nine-bit diagnostic field held in word
// - Interrupt needs enable, mask and pending
// - Kernel wide bit gives 64-bit addressing
// - Supervisor wide bit gives 64-bit operation
// - User wide bit gives 64-bit operation
// - Mode field: 10 user, 01 super, 00 kernel
// - Error level bit kept
// - Exception level bit kept
// - Global interrupt enable bit kept
// - Boot bit selects bootstrap exception vectors
// - Shutdown flag set by hardware, read-only
// - Soft reset flag marks last reset soft
// - Lookup hit bit records last secondary hit
// - Override bit uses ECC register check bits
// - Trap disable bit blocks parity exceptions
// - Reserved diagnostic bits read as zero
module psw_status_reg
(
    // Clock and reset
    input  wire logic               clock_i,
    input  wire logic               srst_i,
    // Register port
    input  wire logic [3:0]         addr_i,
    input  wire logic [31:0]        wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire logic               privileged_i,
    output logic      [31:0]        rdata_o,
    // Core events
    input  wire logic [7:0]         pending_i,
    input  wire logic               tlb_shutdown_i,
    input  wire logic               soft_reset_i,
    input  wire logic               l2_hit_valid_i,
    input  wire logic               l2_hit_i,
    // Decoded controls
    output psw_pkg::psw_ctrl_s      ctrl_o,
    output psw_pkg::psw_mode_e      mode_o,
    output logic                    clk_en_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0]           status_ff;
    logic [31:0]           nxt_status;
    logic                  soft_seen_ff;
    logic [1:0]            div_ff;
    logic [31:0]           rdata_ff;
    psw_pkg::psw_ctrl_s    ctrl_ff;
    psw_pkg::psw_mode_e    mode_ff;
    logic                  clk_en_ff;

    // All checks below share this clock and reset
    default clocking chk_cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire       wr_ok     = wr_i & privileged_i &
                           (addr_i == psw_pkg::ADDR_STATUS);
    wire       rd_ok     = rd_i & privileged_i;
    wire [1:0] priv_mode = status_ff[psw_pkg::PRIV_MODE_LSB +: 2];
    wire       err_lvl   = status_ff[psw_pkg::ERR_LEVEL_BIT];
    wire       exc_lvl   = status_ff[psw_pkg::EXC_LEVEL_BIT];

    // Either level bit forces kernel regardless of the mode field
    wire       in_kern   = (priv_mode == 2'h0) |
                           err_lvl | exc_lvl;
    wire       in_user   = ~err_lvl & ~exc_lvl &
                           (priv_mode == 2'h2);
    wire       in_sup    = ~err_lvl & ~exc_lvl &
                           (priv_mode == 2'h1);

    psw_pkg::psw_mode_e nxt_mode;
    assign nxt_mode = in_user ? psw_pkg::MODE_USER :
                      in_sup  ? psw_pkg::MODE_SUPER :
                                psw_pkg::MODE_KERNEL;

    // ------------------------------------------------------------
    // Coprocessor and wide addressing
    // ------------------------------------------------------------
    wire [3:0] cop_bits  = status_ff[psw_pkg::COP_USABLE_LSB +: 4];
    wire [3:0] cop_eff   = {cop_bits[3:1],
                            cop_bits[0] | in_kern};

    wire       kern_wide = status_ff[psw_pkg::KERN_WIDE_BIT];
    wire       sup_wide  = status_ff[psw_pkg::SUP_WIDE_BIT];
    wire       user_wide = status_ff[psw_pkg::USER_WIDE_BIT];
    wire       wide_a    = (in_kern & kern_wide) |
                           (in_sup & sup_wide) |
                           (in_user & user_wide);
    // Kernel keeps 64-bit operations; only its addressing is switched
    wire       wide_o    = in_kern |
                           (in_sup & sup_wide) |
                           (in_user & user_wide);

    // ------------------------------------------------------------
    // Interrupt gate
    // ------------------------------------------------------------
    wire [7:0] int_mask  = status_ff[psw_pkg::INT_MASK_LSB +: 8];
    wire       int_en    = status_ff[psw_pkg::INT_ENABLE_BIT];
    wire       irq       = int_en & ~exc_lvl & ~err_lvl &
                           |(int_mask & pending_i);

    // ------------------------------------------------------------
    // Control word
    // ------------------------------------------------------------
    psw_pkg::psw_ctrl_s nxt_ctrl;
    assign nxt_ctrl.cop_usable          = cop_eff;
    assign nxt_ctrl.fpr32               =
        status_ff[psw_pkg::FPU_REGS_BIT];
    assign nxt_ctrl.byte_swap           =
        status_ff[psw_pkg::BYTE_SWAP_BIT] & in_user;
    assign nxt_ctrl.wide_addr           = wide_a;
    assign nxt_ctrl.wide_ops            = wide_o;
    assign nxt_ctrl.boot_vectors        =
        status_ff[psw_pkg::BOOT_VEC_BIT];
    assign nxt_ctrl.check_override      =
        status_ff[psw_pkg::CHECK_OVR_BIT];
    assign nxt_ctrl.parity_trap_disable =
        status_ff[psw_pkg::PARITY_DIS_BIT];
    assign nxt_ctrl.int_request         = irq;

    // ------------------------------------------------------------
    // Next status word
    // ------------------------------------------------------------
    // Hardware flags win over a software write in the same cycle
    wire [31:0] sw_val       = wr_ok ? (wdata_i & psw_pkg::WRITE_MASK)
                                     : (status_ff & psw_pkg::WRITE_MASK);
    wire        shutdown_nxt = status_ff[psw_pkg::SHUTDOWN_BIT] |
                               tlb_shutdown_i;
    wire        hit_nxt      = l2_hit_valid_i ? l2_hit_i :
                               status_ff[psw_pkg::L2_HIT_BIT];

    always_comb
    begin
        nxt_status = sw_val;
        nxt_status[psw_pkg::SHUTDOWN_BIT] = shutdown_nxt;
        nxt_status[psw_pkg::L2_HIT_BIT]   = hit_nxt;
    end

    // Low power: enable pulses once per divider period instead of always
    wire div_end = (div_ff == psw_pkg::CLK_DIV_LAST);
    wire lp      = status_ff[psw_pkg::LOW_POWER_BIT];

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    wire [31:0] rd_val = (addr_i == psw_pkg::ADDR_STATUS) ?
                             (status_ff & psw_pkg::READ_MASK) :
                         (addr_i == psw_pkg::ADDR_PENDING) ?
                             {24'h000000, pending_i} :
                         (addr_i == psw_pkg::ADDR_EVENT) ?
                             {31'h00000000, soft_seen_ff} :
                             32'h0000_0000;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            status_ff <= psw_pkg::STATUS_RESET;
        end
        else if (soft_reset_i)
        begin
            // Soft reset enters boot state, error level, flag set
            status_ff <= psw_pkg::STATUS_RESET
                         | (32'h1 << psw_pkg::SOFT_RST_BIT);
        end
        else
        begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            soft_seen_ff <= 1'b0;
        else if (soft_reset_i)
            soft_seen_ff <= 1'b1;
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            div_ff <= 2'h0;
        else
            div_ff <= div_end ? 2'h0 : div_ff + 2'h1;
    end

    // Enable stays high through reset so the core is never frozen
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            clk_en_ff <= 1'b1;
        else
            clk_en_ff <= ~lp | div_end;
    end

    // Controls lag the word by one cycle to keep outputs registered
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            ctrl_ff <= '0;
            mode_ff <= psw_pkg::MODE_KERNEL;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            mode_ff <= nxt_mode;
        end
    end

    // Read data stand one cycle only, zero otherwise
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            rdata_ff <= 32'h0000_0000;
        else
            rdata_ff <= rd_ok ? rd_val : 32'h0000_0000;
    end

    assign rdata_o  = rdata_ff;
    assign ctrl_o   = ctrl_ff;
    assign mode_o   = mode_ff;
    assign clk_en_o = clk_en_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_cop0_kernel: assert property (
        in_kern |=> ctrl_o.cop_usable[0])
        else $error("cop0 not usable in kernel");

    a_cop_upper: assert property (
        1'b1 |=> ctrl_o.cop_usable[3:1] == $past(cop_bits[3:1]))
        else $error("coprocessor usable bits not passed");

    a_irq_gate: assert property (
        ctrl_o.int_request |-> $past(int_en))
        else $error("interrupt raised while disabled");

    a_irq_off: assert property (
        !int_en |=> !ctrl_o.int_request)
        else $error("interrupt raised with enable clear");

    a_swap_user: assert property (
        ctrl_o.byte_swap |-> $past(in_user))
        else $error("byte swap outside user mode");

    a_fpu_count: assert property (
        1'b1 |=> ctrl_o.fpr32 == $past(status_ff[26]))
        else $error("register count bit not passed");

    a_kern_wide: assert property (
        (in_kern && kern_wide) |=> ctrl_o.wide_addr)
        else $error("kernel wide addressing missing");

    a_sup_wide: assert property (
        in_sup |=> ctrl_o.wide_ops == $past(sup_wide))
        else $error("supervisor wide operation wrong");

    a_user_wide: assert property (
        in_user |=> ctrl_o.wide_addr == $past(user_wide))
        else $error("user wide addressing wrong");

    a_mode_hot: assert property (
        $onehot(mode_o))
        else $error("mode output not one-hot");

    a_mode_user: assert property (
        in_user |=> mode_o == psw_pkg::MODE_USER)
        else $error("user mode not shown");

    a_err_kern: assert property (
        err_lvl |=> mode_o == psw_pkg::MODE_KERNEL)
        else $error("error level not in kernel");

    a_exc_kern: assert property (
        exc_lvl |=> mode_o == psw_pkg::MODE_KERNEL)
        else $error("exception level not in kernel");

    a_boot_vec: assert property (
        1'b1 |=> ctrl_o.boot_vectors == $past(status_ff[22]))
        else $error("boot vector bit not passed");

    a_check_ovr: assert property (
        1'b1 |=> ctrl_o.check_override == $past(status_ff[17]))
        else $error("check override bit not passed");

    a_parity_dis: assert property (
        1'b1 |=> ctrl_o.parity_trap_disable == $past(status_ff[16]))
        else $error("parity trap disable not passed");

    a_shutdown_sticky: assert property (
        (tlb_shutdown_i && !soft_reset_i) |=>
            status_ff[21] [*2])
        else $error("shutdown flag lost");

    a_shutdown_ro: assert property (
        (wr_ok && !tlb_shutdown_i && !soft_reset_i) |=>
            $stable(status_ff[21]))
        else $error("shutdown flag changed by write");

    a_resv_zero: assert property (
        (status_ff[23] == 1'b0) && (status_ff[19] == 1'b0))
        else $error("reserved bit set");

    a_write_once: assert property (
        (wr_ok && !soft_reset_i) |=>
            status_ff[15:0] == $past(wdata_i[15:0]))
        else $error("write not taken in one cycle");

    a_rd_idle: assert property (
        !rd_ok |=> rdata_o == 32'h0000_0000)
        else $error("read data outside read cycle");

    a_low_power: assert property (
        (lp && $past(lp) && $past(lp, 2) && clk_en_o) |=>
            !clk_en_o)
        else $error("low power enable not divided");

    a_full_speed: assert property (
        !lp |=> clk_en_o)
        else $error("enable dropped at full speed");

    a_soft_flag: assert property (
        soft_reset_i |=> status_ff[20] && status_ff[22])
        else $error("soft reset not recorded");

    a_hit_rec: assert property (
        (l2_hit_valid_i && !soft_reset_i) |=>
            status_ff[18] == $past(l2_hit_i))
        else $error("lookup hit not recorded");

endmodule

// >>> tb.sv
// Purpose: Self-checking bench for the processor status word bank
// Assumes: Bench drives every port itself; strobes by NBA after an edge
// Notes:   ctrl_o and mode_o are checked two edges after a write lands
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                 clock_i;
    logic                 srst_i;
    logic [3:0]           addr_i;
    logic [31:0]          wdata_i;
    logic                 wr_i;
    logic                 rd_i;
    logic                 privileged_i;
    logic [31:0]          rdata_o;
    logic [7:0]           pending_i;
    logic                 tlb_shutdown_i;
    logic                 soft_reset_i;
    logic                 l2_hit_valid_i;
    logic                 l2_hit_i;
    psw_pkg::psw_ctrl_s   ctrl_o;
    psw_pkg::psw_mode_e   mode_o;
    logic                 clk_en_o;
    int                   n_fail;
    int                   n_compared;
    psw_status_reg i_dut (.clock_i(clock_i), .srst_i(srst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .privileged_i(privileged_i), .rdata_o(rdata_o),
        .pending_i(pending_i), .tlb_shutdown_i(tlb_shutdown_i),
        .soft_reset_i(soft_reset_i), .l2_hit_valid_i(l2_hit_valid_i),
        .l2_hit_i(l2_hit_i), .ctrl_o(ctrl_o), .mode_o(mode_o),
        .clk_en_o(clk_en_o));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1;
        chk_word(rdata_o, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_mask();
        rd_chk(psw_pkg::ADDR_STATUS, 32'h0040_0004);
        chk_word(32'(mode_o), 32'(psw_pkg::MODE_KERNEL));
        wr(psw_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        rd_chk(psw_pkg::ADDR_STATUS, 32'hFE53_FFFF);
        wr(psw_pkg::ADDR_STATUS, 32'h0000_0000);
        rd_chk(psw_pkg::ADDR_STATUS, 32'h0000_0000);
    endtask
    task automatic t_modes();
        wr(psw_pkg::ADDR_STATUS, 32'h0200_0030);
        settle();
        chk_word(32'(mode_o), 32'(psw_pkg::MODE_USER));
        chk_word(32'(ctrl_o.byte_swap), 32'h1);
        chk_word(32'(ctrl_o.cop_usable), 32'h0);
        chk_word(32'(ctrl_o.wide_ops), 32'h1);
        wr(psw_pkg::ADDR_STATUS, 32'h0000_0048);
        settle();
        chk_word(32'(mode_o), 32'(psw_pkg::MODE_SUPER));
        chk_word(32'(ctrl_o.wide_ops), 32'h1);
        wr(psw_pkg::ADDR_STATUS, 32'hA600_0080);
        settle();
        chk_word(32'(mode_o), 32'(psw_pkg::MODE_KERNEL));
        chk_word(32'(ctrl_o.byte_swap), 32'h0);
        chk_word(32'(ctrl_o.cop_usable), 32'hB);
        chk_word(32'(ctrl_o.fpr32), 32'h1);
        chk_word(32'(ctrl_o.wide_addr), 32'h1);
    endtask
    task automatic t_interrupt();
        wr(psw_pkg::ADDR_STATUS, 32'h0000_0801);
        pending_i <= 8'h04;
        settle();
        chk_word(32'(ctrl_o.int_request), 32'h0);
        pending_i <= 8'h08;
        settle();
        chk_word(32'(ctrl_o.int_request), 32'h1);
        wr(psw_pkg::ADDR_STATUS, 32'h0000_0800);
        settle();
        chk_word(32'(ctrl_o.int_request), 32'h0);
        pending_i <= 8'h00;
    endtask
    task automatic t_events();
        @(posedge clock_i);
        tlb_shutdown_i <= 1'b1;
        l2_hit_valid_i <= 1'b1;
        l2_hit_i       <= 1'b1;
        @(posedge clock_i);
        tlb_shutdown_i <= 1'b0;
        l2_hit_valid_i <= 1'b0;
        wr(psw_pkg::ADDR_STATUS, 32'h0000_0000);
        rd_chk(psw_pkg::ADDR_STATUS, 32'h0024_0000);
        @(posedge clock_i);
        soft_reset_i <= 1'b1;
        @(posedge clock_i);
        soft_reset_i <= 1'b0;
        rd_chk(psw_pkg::ADDR_STATUS, 32'h0050_0004);
    endtask
    task automatic t_refused();
        privileged_i <= 1'b0;
        wr(psw_pkg::ADDR_STATUS, 32'h0000_0001);
        rd_chk(psw_pkg::ADDR_STATUS, 32'h0000_0000);
        privileged_i <= 1'b1;
        wr(4'hF, 32'h0000_0001);
        rd_chk(4'hF, 32'h0000_0000);
        rd_chk(psw_pkg::ADDR_STATUS, 32'h0050_0004);
        rd_chk(psw_pkg::ADDR_EVENT, 32'h0000_0001);
        @(posedge clock_i);
        #1;
        chk_word(rdata_o, 32'h0000_0000);
        pending_i <= 8'hA5;
        rd_chk(psw_pkg::ADDR_PENDING, 32'h0000_00A5);
        pending_i <= 8'h00;
    endtask
    task automatic t_low_power();
        int n;
        n = 0;
        wr(psw_pkg::ADDR_STATUS, 32'h0800_0000);
        settle();
        repeat (8)
        begin
            @(posedge clock_i);
            #1;
            n = n + int'(clk_en_o === 1'b1);
        end
        chk_word(32'(n), 32'h2);
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial
    begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial
    begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial
    begin
        n_fail = 0;
        n_compared = 0;
        srst_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 32'h0000_0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        privileged_i = 1'b1;
        pending_i = 8'h00;
        tlb_shutdown_i = 1'b0;
        soft_reset_i = 1'b0;
        l2_hit_valid_i = 1'b0;
        l2_hit_i = 1'b0;
        repeat (4) @(posedge clock_i);
        srst_i <= 1'b0;
        t_reset_and_mask();
        t_modes();
        t_interrupt();
        t_events();
        t_refused();
        t_low_power();
        end_sim();
    end
endmodule
